// ===== rtl/ppac_pkg.sv
// Package for the pump and band-calibration configuration bank.
// Assumes a 25 MHz system clock that also stands in for the reference.
package ppac_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_CURVE     = 6'h05;     // Tuning curve word
   localparam logic [5:0]  IDX_PUMP      = 6'h09;     // Pump current control
   localparam logic [5:0]  IDX_CAL       = 6'h0a;     // Band calibration config
   localparam logic [5:0]  IDX_STAT      = 6'h10;     // Calibration status
   localparam int          REG_W         = 24;        // Register width
   // Reset values
   localparam logic [23:0] CURVE_RST     = 24'h000000;
   localparam logic [23:0] PUMP_RST      = 24'h403264;
   localparam logic [23:0] CAL_RST       = 24'h002205;
   localparam logic [23:0] CAL_MASK      = 24'h01ffff; // Defined calibration bits
   // Pump word fields
   localparam int          SINK_LSB      = 0;
   localparam int          SOURCE_LSB    = 7;
   localparam int          OFFSET_LSB    = 14;
   localparam int          OFS_UP_BIT    = 21;
   localparam int          OFS_DN_BIT    = 22;
   localparam int          HICP_BIT      = 23;
   // Calibration word fields
   localparam int          MLEN_LSB      = 0;
   localparam int          TOFS_LSB      = 3;
   localparam int          WAIT_LSB      = 6;
   localparam int          DEPTH_LSB     = 8;
   localparam int          FORCE_BIT     = 10;
   localparam int          SKIP_BIT      = 11;
   localparam int          NOTRIG_BIT    = 12;
   localparam int          CDIV_LSB      = 13;
   localparam int          FALL_BIT      = 15;
   localparam int          RBYP_BIT      = 16;
   // Status word fields
   localparam int          STAT_BUSY_BIT = 8;
   localparam int          STAT_LINK_BIT = 9;
   // Timing, in calibration clock periods
   localparam int          START_WAIT    = 100;
   localparam logic [6:0]  WAIT_LAST     = 7'(START_WAIT - 1);
   localparam int          REF_DIV_RATIO = 2;        // Reference divider cycle in ticks
   localparam int          LINK_W        = 8;        // Bits per tuning link transfer
   // Calibration clock divider terminal counts
   localparam logic [4:0]  DIV1_LAST     = 5'h00;
   localparam logic [4:0]  DIV4_LAST     = 5'h03;
   localparam logic [4:0]  DIV16_LAST    = 5'h0f;
   localparam logic [4:0]  DIV32_LAST    = 5'h1f;
endpackage

// ===== rtl/ppac_tick_div.sv
// Calibration clock enable divider.
// Assumes the system clock stands for the crystal reference.
`timescale 1ns/100ps
module ppac_tick_div
   import ppac_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [1:0] div_sel,   // 0:/1 1:/4 2:/16 3:/32
   input  wire logic       fall_sel,  // Use the opposite half of the period
   output logic            tick       // One-cycle calibration clock enable
);
   logic [4:0] cnt_reg;               // Phase counter
   logic [4:0] term;                  // Selected terminal count
   logic       hit;                   // Phase match

   assign term = (div_sel == 2'd0) ? DIV1_LAST :
                 (div_sel == 2'd1) ? DIV4_LAST :
                 (div_sel == 2'd2) ? DIV16_LAST : DIV32_LAST;
   // Falling edge is emulated as the mid-period phase of the divided clock
   assign hit  = fall_sel ? (cnt_reg == (term >> 1)) : (cnt_reg == term);

   // Counter wraps early if the selection shrinks mid-count
   always_ff @(posedge clk_sys) begin
      if (rst || cnt_reg >= term)
         cnt_reg <= 5'h00;
      else
         cnt_reg <= cnt_reg + 5'h01;
   end

   // Registered enable
   always_ff @(posedge clk_sys) begin
      if (rst)
         tick <= 1'b0;
      else
         tick <= hit;
   end
endmodule

// ===== rtl/ppac_link_tx.sv
// Serialiser for the internal tuning link, one bit per calibration tick.
// Assumes start pulses only while not busy.
`timescale 1ns/100ps
module ppac_link_tx
   import ppac_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              tick,      // Calibration clock enable
   input  wire logic              start,     // Load word and begin
   input  wire logic [LINK_W-1:0] word,      // Word to send, MSB first
   output logic                   link_data, // Serial data
   output logic                   link_valid,// High while a bit is presented
   output logic                   busy       // Transfer in progress
);
   logic [LINK_W-1:0] shift_reg;             // Remaining bits
   logic [3:0]        left_reg;              // Bits still to send

   assign busy = (left_reg != 4'h0);

   // Shift one bit out per tick
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shift_reg  <= '0;
         left_reg   <= 4'h0;
         link_data  <= 1'b0;
         link_valid <= 1'b0;
      end else if (start && !busy) begin
         shift_reg  <= word;
         left_reg   <= 4'(LINK_W);
      end else if (tick && busy) begin
         link_data  <= shift_reg[LINK_W-1];
         link_valid <= 1'b1;
         shift_reg  <= {shift_reg[LINK_W-2:0], 1'b0};
         left_reg   <= left_reg - 4'h1;
      end else if (tick) begin
         // Line returns idle one tick after the last bit
         link_valid <= 1'b0;
         link_data  <= 1'b0;
      end
   end
endmodule

// ===== rtl/ppac_top.sv
// Pump current and band calibration configuration bank with its
// calibration engine and tuning link, behind an Avalon-MM slave.
// Assumes one 25 MHz clock that also serves as the reference, and a
// comparator input from the frequency counter during measurements.
//
// Notes on behaviour
// RULE_01 - Sink current code, bits 6:0, reset 100
// RULE_02 - Source current code, bits 13:7, reset 100
// RULE_03 - Offset magnitude code, bits 20:14, reset 0
// RULE_04 - Software keeps up-offset off, down-offset per mode
// RULE_05 - Bit 23 selects high-current pump, reset 0
// RULE_06 - Measurement cycles 1, 2, 4 up to 256
// RULE_07 - Curve offset: 1..3 up, 4..7 down
// RULE_08 - Startup wait, then waits after N measurements
// RULE_09 - Search depth code gives 8 to 5 bits
// RULE_10 - Force sends curve word; skip bypasses search
// RULE_11 - Curve writes trigger link unless suppressed
// RULE_12 - Calibration clock is reference divided 1/4/16/32
// RULE_13 - Falling-edge option shifts calibration clock phase
// RULE_14 - Bit 16 forces reference divider bypass
// RULE_15 - Undefined calibration bits read zero, ignore writes
`timescale 1ns/100ps
module ppac_top
   import ppac_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        vco_above_target,
   output logic [6:0]       pump_sink_current_code,
   output logic [6:0]       pump_source_current_code,
   output logic [6:0]       pump_offset_current_code,
   output logic             offset_upward_enable,
   output logic             offset_downward_enable,
   output logic             high_current_pump_select,
   output logic             reference_divider_bypass,
   output logic [7:0]       band_select,
   output logic             cal_busy,
   output logic             tuning_link_data,
   output logic             tuning_link_valid
);
   import ppac_pkg::*;

   // Calibration engine states
   typedef enum logic [2:0] {
      ST_IDLE, ST_START_WAIT, ST_MEAS, ST_STEP_WAIT, ST_APPLY, ST_SEND, ST_DRAIN
   } ppac_state_t;

   // Measurement length in reference-divider cycles
   function automatic logic [8:0] meas_cycles(input logic [2:0] code);
      if (code == 3'd7)
         meas_cycles = 9'h100;
      else
         meas_cycles = 9'h001 << code;
   endfunction

   // Bus-side storage
   logic [23:0] curve_reg;             // Tuning curve word
   logic [23:0] pump_reg;              // Pump current control
   logic [23:0] cal_reg;               // Calibration config
   logic        ack_reg;               // Second cycle of an access
   logic [31:0] rdata_reg;             // Registered read data

   // Calibration engine state
   ppac_state_t state_reg;
   ppac_state_t state_next;
   logic [6:0]  wait_reg;              // Wait period counter
   logic [9:0]  meas_reg;              // Ticks left in a measurement
   logic [2:0]  bit_reg;               // Bit under trial
   logic [1:0]  done_meas_reg;         // Measurements finished, saturating
   logic [7:0]  band_reg;              // Search register
   logic [7:0]  result_reg;            // Last applied band

   // Decode
   wire  [5:0]  idx        = avs_address[7:2];
   wire         aligned    = (avs_address[1:0] == 2'b00);
   wire         wr_go      = avs_write && ack_reg && aligned;
   wire         wr_curve   = wr_go && (idx == IDX_CURVE);
   wire         wr_pump    = wr_go && (idx == IDX_PUMP);
   wire         wr_cal     = wr_go && (idx == IDX_CAL);
   wire  [23:0] be_mask    = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                              {8{avs_byteenable[0]}}};
   wire  [23:0] wdata      = avs_writedata[23:0];

   // Calibration fields
   wire  [2:0]  mlen_code  = cal_reg[MLEN_LSB +: 3];
   wire  [2:0]  tofs_code  = cal_reg[TOFS_LSB +: 3];
   wire  [1:0]  wait_code  = cal_reg[WAIT_LSB +: 2];
   wire  [1:0]  depth_code = cal_reg[DEPTH_LSB +: 2];
   wire         force_curve= cal_reg[FORCE_BIT];
   wire         skip_band_search           = cal_reg[SKIP_BIT];
   wire         suppress_tuning_link_write = cal_reg[NOTRIG_BIT];
   wire  [1:0]  calibration_clock_divider  = cal_reg[CDIV_LSB +: 2];
   wire         calibration_falling_edge   = cal_reg[FALL_BIT];

   // Engine helpers
   wire         tick;                  // Calibration clock enable
   wire         link_busy;             // Tuning link transfer running
   wire         trigger    = wr_curve && !suppress_tuning_link_write; // RULE_11
   wire  [2:0]  last_bit   = 3'(depth_code);                          // RULE_09
   wire  [9:0]  ref_mult   = reference_divider_bypass ? 10'd1 : 10'(REF_DIV_RATIO);
   wire  [9:0]  meas_len   = 10'(meas_cycles(mlen_code)) * ref_mult;  // RULE_06
   wire  [7:0]  trial_bit  = 8'h01 << bit_reg;
   wire  [7:0]  kept_band  = vco_above_target ? (band_reg & ~trial_bit) : band_reg;
   wire         more_waits = ({1'b0, done_meas_reg} < {1'b0, wait_code}); // RULE_08
   // Signed curve offset: 4..7 read as -4..-1
   wire  signed [9:0] ofs_s   = 10'(signed'(tofs_code));                // RULE_07
   wire  signed [9:0] sum_s   = signed'({2'b00, band_reg}) + ofs_s;
   wire  [7:0]  adj_band   = (sum_s < 0) ? 8'h00 :
                             (sum_s > 10'sd255) ? 8'hff : sum_s[7:0];
   wire  [7:0]  send_word  = force_curve ? curve_reg[7:0] : result_reg;  // RULE_10
   wire         send_start = (state_reg == ST_SEND) && !link_busy;

   // Pump fields straight from storage
   assign pump_sink_current_code   = pump_reg[SINK_LSB +: 7];          // RULE_01
   assign pump_source_current_code = pump_reg[SOURCE_LSB +: 7];        // RULE_02
   assign pump_offset_current_code = pump_reg[OFFSET_LSB +: 7];        // RULE_03
   // Offset enables pass as written; software picks them per mode
   assign offset_upward_enable     = pump_reg[OFS_UP_BIT];             // RULE_04
   assign offset_downward_enable   = pump_reg[OFS_DN_BIT];             // RULE_04
   assign high_current_pump_select = pump_reg[HICP_BIT];               // RULE_05
   assign reference_divider_bypass = cal_reg[RBYP_BIT];                // RULE_14
   assign band_select              = result_reg;
   assign cal_busy                 = (state_reg != ST_IDLE);
   assign avs_readdata             = rdata_reg;
   // One wait cycle, then the access completes
   assign avs_waitrequest          = (avs_read || avs_write) && !ack_reg;

   // Read mux; unmapped and unaligned addresses read zero
   wire  [23:0] rd_mux =
      !aligned            ? 24'h000000 :
      (idx == IDX_CURVE)  ? curve_reg :
      (idx == IDX_PUMP)   ? pump_reg :
      (idx == IDX_CAL)    ? (cal_reg & CAL_MASK) :                     // RULE_15
      (idx == IDX_STAT)   ? {14'h0000, link_busy, cal_busy, result_reg} :
                            24'h000000;

   // Access sequencer: ack on the second cycle of every request
   always_ff @(posedge clk_sys) begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read || avs_write) && !ack_reg;
   end

   // Read data captured in the wait cycle, stands at the completing edge
   always_ff @(posedge clk_sys) begin
      if (rst)
         rdata_reg <= 32'h00000000;
      else if (avs_read && !ack_reg)
         rdata_reg <= {8'h00, rd_mux};
   end

   // Curve word
   always_ff @(posedge clk_sys) begin
      if (rst)
         curve_reg <= CURVE_RST;
      else if (wr_curve)
         curve_reg <= (curve_reg & ~be_mask) | (wdata & be_mask);
   end

   // Pump word
   always_ff @(posedge clk_sys) begin
      if (rst)
         pump_reg <= PUMP_RST;                                         // RULE_01
      else if (wr_pump)
         pump_reg <= (pump_reg & ~be_mask) | (wdata & be_mask);
   end

   // Calibration word; undefined bits never store
   always_ff @(posedge clk_sys) begin
      if (rst)
         cal_reg <= CAL_RST;                                           // RULE_06
      else if (wr_cal)
         cal_reg <= ((cal_reg & ~be_mask) | (wdata & be_mask)) & CAL_MASK; // RULE_15
   end

   // Next state of the calibration engine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (trigger)
               state_next = skip_band_search ? ST_SEND : ST_START_WAIT; // RULE_10
         end
         ST_START_WAIT: begin
            if (tick && wait_reg == WAIT_LAST)
               state_next = ST_MEAS;                                   // RULE_08
         end
         ST_MEAS: begin
            if (tick && meas_reg == 10'd1) begin
               if (more_waits)
                  state_next = ST_STEP_WAIT;                           // RULE_08
               else if (bit_reg == last_bit)
                  state_next = ST_APPLY;
            end
         end
         ST_STEP_WAIT: begin
            if (tick && wait_reg == WAIT_LAST)
               state_next = (bit_reg == last_bit) ? ST_APPLY : ST_MEAS;
         end
         ST_APPLY: begin
            state_next = ST_SEND;
         end
         ST_SEND: begin
            if (!link_busy)
               state_next = ST_DRAIN;
         end
         ST_DRAIN: begin
            if (!link_busy && !tuning_link_valid)
               state_next = ST_IDLE;
         end
      endcase
   end

   // Engine state register
   always_ff @(posedge clk_sys) begin
      if (rst)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Wait counter, cleared on entering either wait state
   always_ff @(posedge clk_sys) begin
      if (rst || (state_next != state_reg))
         wait_reg <= 7'h00;
      else if (tick && (state_reg == ST_START_WAIT || state_reg == ST_STEP_WAIT))
         wait_reg <= wait_reg + 7'h01;
   end

   // Measurement counter, loaded on entering a measurement
   always_ff @(posedge clk_sys) begin
      if (rst)
         meas_reg <= 10'd0;
      else if (state_next == ST_MEAS && state_reg != ST_MEAS)
         meas_reg <= meas_len;                                         // RULE_06
      else if (state_reg == ST_MEAS && tick && meas_reg == 10'd1 && state_next == ST_MEAS)
         meas_reg <= meas_len;
      else if (state_reg == ST_MEAS && tick)
         meas_reg <= meas_reg - 10'd1;
   end

   // Successive approximation: trial bit set, dropped if VCO runs high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         band_reg      <= 8'h00;
         bit_reg       <= 3'd7;
         done_meas_reg <= 2'd0;
      end else if (state_reg == ST_IDLE && trigger) begin
         band_reg      <= 8'h80;
         bit_reg       <= 3'd7;
         done_meas_reg <= 2'd0;
      end else if (state_reg == ST_MEAS && tick && meas_reg == 10'd1) begin
         // Bits below the search depth stay zero
         band_reg      <= (bit_reg == last_bit) ? kept_band
                                                : (kept_band | (trial_bit >> 1)); // RULE_09
         if (bit_reg != last_bit)
            bit_reg    <= bit_reg - 3'd1;
         if (done_meas_reg != 2'd3)
            done_meas_reg <= done_meas_reg + 2'd1;
      end
   end

   // Applied band: search result plus the temperature curve offset, or the curve word when the search is skipped
   always_ff @(posedge clk_sys) begin
      if (rst)
         result_reg <= 8'h00;
      else if (state_reg == ST_APPLY)
         result_reg <= adj_band;                                       // RULE_07
      else if (state_reg == ST_SEND && send_start && skip_band_search)
         result_reg <= curve_reg[7:0];                                 // RULE_10
   end

   // Calibration clock from the reference
   ppac_tick_div u_tick_div (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .div_sel  (calibration_clock_divider),                           // RULE_12
      .fall_sel (calibration_falling_edge),                            // RULE_13
      .tick     (tick)
   );

   // Tuning link transfer of the selected band word
   ppac_link_tx u_link_tx (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .tick       (tick),
      .start      (send_start),
      .word       (skip_band_search ? curve_reg[7:0] : send_word),    // RULE_10
      .link_data  (tuning_link_data),
      .link_valid (tuning_link_valid),
      .busy       (link_busy)
   );
endmodule

// ===== verification/ppac_assertions.sv
// Checker for the pump and band calibration bank.
// Sees only the ports of ppac_top; bound at the foot.
`timescale 1ns/100ps
module ppac_assertions
   import ppac_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [6:0]  pump_sink_current_code,
   input wire logic [6:0]  pump_source_current_code,
   input wire logic [6:0]  pump_offset_current_code,
   input wire logic        offset_upward_enable,
   input wire logic        offset_downward_enable,
   input wire logic        high_current_pump_select,
   input wire logic        reference_divider_bypass,
   input wire logic        cal_busy,
   input wire logic        tuning_link_valid
);
   logic [8:0] vlen_reg;   // Cycles of the current link transfer
   wire        curve_wr = avs_write && !avs_waitrequest && avs_address == 8'h14;  // Curve write completes
   wire [23:0] pump_word = {high_current_pump_select, offset_downward_enable, offset_upward_enable,
                            pump_offset_current_code, pump_source_current_code, pump_sink_current_code};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Valid cycles so far
   always_ff @(posedge clk_sys) begin
      if (rst || !tuning_link_valid)
         vlen_reg <= 9'h000;
      else
         vlen_reg <= vlen_reg + 9'h001;
   end

   // Completed writes to the two configuration words
   sequence s_pump_wr;
      avs_write && !avs_waitrequest && avs_address == 8'h24;
   endsequence
   sequence s_cal_wr;
      avs_write && !avs_waitrequest && avs_address == 8'h28;
   endsequence

   // Never disabled: reset beats any bus traffic
   property p_rst_pump;
      disable iff (1'b0) rst |=> pump_word == PUMP_RST && !reference_divider_bypass;
   endproperty
   property p_sink;
      s_pump_wr ##0 avs_byteenable[0] |=> pump_sink_current_code == $past(avs_writedata[6:0]);
   endproperty
   property p_source;
      s_pump_wr ##0 avs_byteenable[1:0] == 2'h3 |=> pump_source_current_code == $past(avs_writedata[13:7]);
   endproperty
   property p_offset;
      s_pump_wr ##0 avs_byteenable[2:1] == 2'h3 |=> pump_offset_current_code == $past(avs_writedata[20:14]);
   endproperty
   property p_high;
      s_pump_wr ##0 avs_byteenable[2] |=> high_current_pump_select == $past(avs_writedata[23]);
   endproperty
   property p_bypass;
      s_cal_wr ##0 avs_byteenable[2] |=> reference_divider_bypass == $past(avs_writedata[16]);
   endproperty
   property p_cal_read;
      avs_read && !avs_waitrequest && avs_address == 8'h28 |-> avs_readdata[31:17] == 15'h0000;
   endproperty
   // Calibration starts one cycle after a curve write
   property p_trigger;
      $rose(cal_busy) |-> $past(curve_wr);
   endproperty
   property p_link_in_cal;
      tuning_link_valid |-> cal_busy;
   endproperty
   // Eight bits at one of the four calibration clock rates
   property p_link_len;
      $fell(tuning_link_valid) |-> vlen_reg inside {9'h008, 9'h020, 9'h080, 9'h100};
   endproperty

   a_rst_pump:    assert property (p_rst_pump) else $error("pump word not at reset value");
   a_sink:        assert property (p_sink) else $error("sink code not written");
   a_source:      assert property (p_source) else $error("source code not written");
   a_offset:      assert property (p_offset) else $error("offset code not written");
   a_high:        assert property (p_high) else $error("high current select not written");
   a_bypass:      assert property (p_bypass) else $error("divider bypass not written");
   a_cal_read:    assert property (p_cal_read) else $error("undefined bits read nonzero");
   a_trigger:     assert property (p_trigger) else $error("calibration without curve write");
   a_link_in_cal: assert property (p_link_in_cal) else $error("link active while idle");
   a_link_len:    assert property (p_link_len) else $error("link transfer length wrong");
endmodule

bind ppac_top ppac_assertions u_ppac_assertions (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pump_sink_current_code,
   .pump_source_current_code, .pump_offset_current_code, .offset_upward_enable, .offset_downward_enable,
   .high_current_pump_select, .reference_divider_bypass, .cal_busy, .tuning_link_valid);

// ===== verification/testbench.sv
// Self-checking bench for the pump and band calibration bank.
// Drives the bus and the comparator; checks reads and link transfers.
`timescale 1ns/100ps
module testbench;
   import ppac_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, avs_read, avs_write, vco_above_target, avs_waitrequest;
   logic [7:0]  avs_address, band_select, word;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [6:0]  pump_sink_current_code, pump_source_current_code, pump_offset_current_code;
   logic offset_upward_enable, offset_downward_enable, high_current_pump_select;
   logic reference_divider_bypass, cal_busy, tuning_link_data, tuning_link_valid;
   int num_errors = 0, check_count = 0, lcnt = 0, dcnt = 0, base = 0, per = 1;
   logic [31:0] exp_rd[$];    // Expected read data, oldest first
   logic [63:0] exp_link[$];  // Band, word, length, busy delta

   always #20 clk_sys = ~clk_sys;

   ppac_top u_ppac_top (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .vco_above_target, .pump_sink_current_code, .pump_source_current_code,
      .pump_offset_current_code, .offset_upward_enable, .offset_downward_enable, .high_current_pump_select,
      .reference_divider_bypass, .band_select, .cal_busy, .tuning_link_data, .tuning_link_valid);

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, want);
      end
   endtask

   task automatic results();
      $display("Mismatches %0d, comparisons %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One bus cycle, held until waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50) begin
         num_errors++;
         results();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_rd.push_back(want);
      bus(1'b0, a, 32'h00000000, 4'hf);
   endtask

   // Band for a steady comparator, plus the curve offset
   function automatic logic [7:0] band_of(input logic [23:0] cw, input logic v);
      int r;
      r = v ? 0 : (255 << cw[9:8]) & 255;
      r = r + ((cw[5:3] < 3'h4) ? int'(cw[5:3]) : int'(cw[5:3]) - 8);
      return (r < 0) ? 8'h00 : ((r > 255) ? 8'hff : 8'(r));
   endfunction

   // One calibration, started by a curve write
   task automatic calib(input logic [23:0] cw, input logic v, input logic [31:0] dl, input logic [7:0] crv,
                        input int p);
      logic [7:0] b;
      int n = 0;
      b = cw[11] ? crv : band_of(cw, v);
      exp_link.push_back({b, (cw[10] | cw[11]) ? crv : b, 16'(8 * p), dl});
      vco_above_target <= v;
      bus(1'b1, 8'h28, {8'h00, cw}, 4'hf);
      bus(1'b1, 8'h14, {24'h000000, crv}, 4'hf);
      while (cal_busy !== 1'b0 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      num_errors += int'(n >= 9000);
      repeat (3) @(posedge clk_sys);
   endtask

   // Reads and link transfers against the oldest notes
   always @(posedge clk_sys) begin
      logic [63:0] e;
      if (avs_read && !avs_waitrequest) check(avs_readdata, exp_rd.pop_front());
      if (tuning_link_valid && exp_link.size() > 0) begin
         per = exp_link[0][47:32] / 8;
         if (lcnt % per == per / 2) word = {word[6:0], tuning_link_data};
         lcnt++;
      end else if (lcnt != 0) begin
         e = exp_link.pop_front();
         check(band_select, e[63:56]);
         check(word, e[55:48]);
         check(lcnt, e[47:32]);
         if (e[31:0] == 32'hffffffff) base = dcnt - lcnt;
         else if (e[31:0] != 32'hfffffffe) check(32'(dcnt - lcnt - base), e[31:0]);
         lcnt = 0;
      end
      dcnt = cal_busy ? dcnt + 1 : 0;
   end

   initial begin
      logic [31:0] r, q;
      int per_t[4] = '{1, 4, 16, 32};
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable, vco_above_target} = '0;
      void'($urandom(32'hbb62));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(8'h24, 32'h00403264);
      rd(8'h28, 32'h00002205);
      rd(8'h30, 32'h00000000);
      r = $urandom() & 32'h00dfffff;
      bus(1'b1, 8'h24, r, 4'hf);
      check({high_current_pump_select, offset_downward_enable, offset_upward_enable, pump_offset_current_code,
             pump_source_current_code, pump_sink_current_code}, r);
      q = $urandom();
      bus(1'b1, 8'h24, q, 4'h2);
      rd(8'h24, (r & 32'h00ff00ff) | (q & 32'h0000ff00));
      bus(1'b1, 8'h28, 32'hffffffff, 4'hf);
      rd(8'h28, 32'h0001ffff);
      check(reference_divider_bypass, 1'b1);
      // Bit 12 set: this curve write starts nothing
      bus(1'b1, 8'h14, 32'h0000005a, 4'hf);
      repeat (4) @(posedge clk_sys);
      check(cal_busy, 1'b0);
      for (int c = 0; c < 4; c++) begin
         calib(24'(32'h800 | (c << 13) | ($urandom() & 32'h8000)), 1'b0, 32'hfffffffe, 8'($urandom()),
               per_t[c]);
      end
      calib(24'h000000, 1'b0, 32'hffffffff, 8'h11, 1);
      calib(24'h000007, 1'b1, 32'h00000ff0, 8'h22, 1);
      calib(24'h0000c0, 1'b0, 32'h0000012c, 8'h33, 1);
      calib(24'h000300, 1'b0, 32'hfffffffa, 8'h44, 1);
      calib(24'h010000, 1'b1, 32'hfffffff8, 8'h55, 1);
      calib(24'h000400, 1'($urandom()), 32'h00000000, 8'h3c, 1);
      for (int c = 1; c < 8; c++) begin
         calib(24'(c << 3), 1'($urandom()), 32'h00000000, 8'h00, 1);
      end
      results();
   end

   // Watchdog, far beyond the run's length
   initial begin
      #1600000;
      num_errors++;
      results();
   end
endmodule
